// [dv/acsc_ctrl_test.sv]
/*
  bench of the converter sequencer: wake, calibration, conversion timing, read-out, buffering.
  assumes the host model reads every result while enabled.
*/
`timescale 1ns/10ps
module acsc_ctrl_test;
  import acsc_pkg::*;
  localparam int CAL_N = 40;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cal_req = 1'b0;
  logic convert_n_r = 1'b1;
  logic tie = 1'b0;
  logic pol = 1'b1;
  logic role = 1'b1;
  logic osc = 1'b0;
  logic en = 1'b0;
  logic [15:0] sample = '0;
  logic convert_n;
  logic chip_sel_n, sclk_in, ready_n, serial_out, serial_out_oe, sclk_out, sclk_out_oe;
  logic [15:0] word;
  int n_rd, lead, tail, n, m, i, r;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;

  assign convert_n = tie ? ready_n : convert_n_r;
  always #50 clk_sys = ~clk_sys;

  acsc_ctrl #(.CAL_CYCLES(CAL_N)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cal_req(cal_req),
    .convert_n(convert_n), .polarity_select(pol), .port_role_select(role), .use_internal_osc(osc),
    .sample_data(sample), .chip_sel_n(chip_sel_n), .sclk_in(sclk_in), .ready_n(ready_n),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .sclk_out(sclk_out),
    .sclk_out_oe(sclk_out_oe));

  acsc_host host_u (.clk_sys(clk_sys), .en(en), .master(role), .ready_n(ready_n),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .sclk_out(sclk_out),
    .sclk_out_oe(sclk_out_oe), .chip_sel_n(chip_sel_n), .sclk_in(sclk_in), .word(word),
    .n_rd(n_rd), .lead(lead), .tail(tail));

  ////////////////////////////////////////////////////////////////////////////
  // checks and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequences
  task automatic wait_rdy(input logic lvl, output int k);
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (ready_n !== lvl && k < 5000);
  endtask

  task automatic do_reset(input logic cal, input logic o, output int k);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    cal_req <= cal;
    osc <= o;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_rdy(1'b0, k);
    @(posedge clk_sys);
    cal_req <= 1'b0;
  endtask

  task automatic wait_read(input int r0);
    for (int j = 0; j < 400 && n_rd == r0; j++) @(negedge clk_sys);
  endtask

  task automatic conv1(input logic [15:0] s, input logic p, input logic ro);
    logic [15:0] exp;
    exp = p ? s : s ^ 16'h8000;
    @(posedge clk_sys);
    sample <= s;
    pol <= p;
    role <= ro;
    convert_n_r <= 1'b0;
    r = n_rd;
    repeat (10) @(posedge clk_sys);
    convert_n_r <= 1'b1;
    en <= 1'b1;
    wait_rdy(1'b0, n);
    chk(32'(n + 10), 81, 84);
    wait_read(r);
    chk(32'(word), 32'(exp), 32'(exp));
    if (ro) begin
      chk(32'(lead), 8, 8);
      chk(32'(tail), 8, 8);
    end else begin
      chk(32'(tail), 1, 8);
    end
    @(posedge clk_sys);
    en <= 1'b0;
  endtask

  initial begin
    do_reset(1'b0, 1'b0, n);
    chk(32'(n), 1535, 1537);
    do_reset(1'b0, 1'b1, n);
    chk(32'(n), 1199, 1201);
    do_reset(1'b1, 1'b0, n);
    chk(32'(n), CAL_N - 1, CAL_N + 1);
    for (i = 0; i < 4; i++) conv1(16'h8001 ^ 16'(i * 4951), i[0], i[1]);
    @(posedge clk_sys);
    convert_n_r <= 1'b0;
    role <= 1'b1;
    pol <= 1'b1;
    en <= 1'b1;
    wait_rdy(1'b0, n);
    wait_rdy(1'b1, n);
    wait_rdy(1'b0, m);
    chk(32'(n + m), 80, 80);
    @(posedge clk_sys);
    tie <= 1'b1;
    for (i = 0; i < 2; i++) begin
      wait_rdy(1'b1, n);
      wait_rdy(1'b0, m);
    end
    chk(32'(n + m), 82, 82);
    wait_rdy(1'b1, n);
    @(posedge clk_sys);
    tie <= 1'b0;
    convert_n_r <= 1'b1;
    repeat (300) @(posedge clk_sys);
    en <= 1'b0;
    convert_n_r <= 1'b0;
    sample <= 16'h5a5a;
    repeat (1600) @(posedge clk_sys);
    convert_n_r <= 1'b1;
    repeat (100) @(posedge clk_sys);
    r = n_rd;
    en <= 1'b1;
    repeat (2000) @(posedge clk_sys);
    chk(32'(n_rd - r), FIFO_DEPTH_DEF + 2, FIFO_DEPTH_DEF + 2);
    chk(32'(word), 32'h5a5a, 32'h5a5a);
    @(negedge clk_sys);
    chk(32'(serial_out_oe), 0, 0);
    chk(32'(sclk_out_oe), 0, 0);
    cal_req <= 1'b1;
    wait_rdy(1'b0, n);
    @(posedge clk_sys);
    cal_req <= 1'b0;
    chk(32'(n), CAL_N - 1, CAL_N + 1);
    end_sim();
  end
endmodule

// [dv/acsc_host.sv]
/*
  host model: reads each result over the serial port, device as clock master or slave.
  assumes the bench sets role and enable; data line has no pull, clock line a pull-down.
*/
`timescale 1ns/10ps
module acsc_host (
  // system side
  input wire logic clk_sys,
  input wire logic en,
  input wire logic master,
  // serial port
  input wire logic ready_n,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic sclk_out,
  input wire logic sclk_out_oe,
  output logic chip_sel_n,
  output logic sclk_in,
  // results
  output logic [15:0] word,
  output int n_rd,
  output int lead,
  output int tail
);
  logic last_r = 1'b0;
  logic sd;
  logic sck;
  int k;

  ////////////////////////////////////////////////////////////////////////////
  // released lines
  assign sd = serial_out_oe ? serial_out : ~last_r;
  assign sck = sclk_out_oe & sclk_out;
  always @(posedge clk_sys) last_r <= sd;

  initial begin
    chip_sel_n = 1'b1;
    sclk_in = 1'b0;
    word = '0;
    n_rd = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sixteen bits per read
  always begin
    wait (en && ready_n === 1'b0);
    @(posedge clk_sys);
    chip_sel_n <= 1'b0;
    lead = -1;
    if (master) begin
      do begin
        @(negedge clk_sys);
        lead++;
      end while (sck !== 1'b1 && lead < 100);
    end
    for (k = 0; k < 16; k++) begin
      if (master) begin
        if (k > 0) while (sck === 1'b1) @(negedge clk_sys);
        while (sck !== 1'b1) @(negedge clk_sys);
        word = {word[14:0], sd};
      end else begin
        if (k == 0) #1337;
        sclk_in = 1'b1;
        #400;
        word = {word[14:0], sd};
        sclk_in = 1'b0;
        if (k < 15) #400;
      end
    end
    tail = 0;
    do begin
      @(negedge clk_sys);
      tail++;
    end while (ready_n !== 1'b1 && tail < 100);
    @(posedge clk_sys);
    chip_sel_n <= 1'b1;
    n_rd++;
    repeat (4) @(posedge clk_sys);
  end
endmodule

// [hw/acsc_ctrl.sv]
/*
  conversion sequencer and serial read-out port: wake-up, calibration, conversion timing,
  ready signalling, master or slave serial clocking, results buffered in a fifo.
  assumes the filter result arrives on sample_data in the system clock domain; all pins are asynchronous.
*/
`timescale 1ns/10ps
module acsc_ctrl
  import acsc_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_MCLK,
  parameter int WORD_W = WORD_W_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control pins
  input wire logic cal_req,
  input wire logic convert_n,
  input wire logic polarity_select,
  input wire logic port_role_select,
  input wire logic use_internal_osc,
  // filter result
  input wire logic [WORD_W-1:0] sample_data,
  // serial port
  input wire logic chip_sel_n,
  input wire logic sclk_in,
  output logic ready_n,
  output logic serial_out,
  output logic serial_out_oe,
  output logic sclk_out,
  output logic sclk_out_oe
);

  localparam int IDX_W = $clog2(WORD_W);

  if (WORD_W < 2 || (1 << IDX_W) != WORD_W || CAL_CYCLES <= SYNC_LAT + 1 ||
      CAL_CYCLES >= (1 << CNT_W)) begin : g_bad_param
    $error("word width must be a power of two and calibration count must fit the counter");
  end

  localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYCLES - 1);
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(WORD_W - 1);

  function automatic logic [WORD_W-1:0] code_word(input logic [WORD_W-1:0] d, input logic bipolar);
    code_word = bipolar ? d : {~d[WORD_W-1], d[WORD_W-2:0]};
  endfunction

  function automatic logic pick_bit(input logic [WORD_W-1:0] w, input logic [IDX_W-1:0] idx);
    pick_bit = w[IDX_LAST - idx];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [PIN_COUNT-1:0] pins_in;
  logic [PIN_COUNT-1:0] syn1_r;
  logic [PIN_COUNT-1:0] syn2_r;
  logic [PIN_COUNT-1:0] syn3_r;

  assign pins_in = {sclk_in, chip_sel_n, use_internal_osc, port_role_select, polarity_select, convert_n, cal_req};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syn1_r <= PIN_RST;
      syn2_r <= PIN_RST;
      syn3_r <= PIN_RST;
    end else begin
      syn1_r <= pins_in;
      syn2_r <= syn1_r;
      syn3_r <= syn2_r;
    end
  end

  logic cal_rise;
  logic convert_n_low;
  logic cs_low;
  logic master;
  logic sclk_fall;

  assign cal_rise = syn2_r[PIN_CAL] && !syn3_r[PIN_CAL];
  assign convert_n_low = !syn2_r[PIN_CONVERT_N];
  assign cs_low = !syn2_r[PIN_CS];
  assign master = syn2_r[PIN_ROLE];
  assign sclk_fall = !syn2_r[PIN_SCLK] && syn3_r[PIN_SCLK];

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  acsc_state_t state_r;
  acsc_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] wake_last;
  logic set_done;
  logic convert_n_start;
  logic push_now;
  logic push_stall;
  logic fifo_in_ready;
  logic pol_r;

  assign wake_last = syn2_r[PIN_OSC] ? WAKE_INT_LAST : WAKE_EXT_LAST;
  assign convert_n_start = (state_r == ST_IDLE) && convert_n_low && !cal_rise;
  assign push_now = (state_r == ST_CONVERT_N) && (cnt_r == PUSH_CNT);
  assign push_stall = push_now && !fifo_in_ready;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 1'b1;
    set_done = 1'b0;
    case (state_r)
      ST_WAKE: begin
        if (cnt_r == wake_last) begin
          state_nxt = ST_IDLE;
          set_done = 1'b1;
        end
      end
      ST_CAL: begin
        if (cnt_r == CAL_LAST) begin
          state_nxt = ST_IDLE;
          set_done = 1'b1;
        end
      end
      ST_IDLE: begin
        cnt_nxt = '0;
        if (convert_n_start) begin
          state_nxt = ST_CONVERT_N;
        end
      end
      ST_CONVERT_N: begin
        if (push_stall) begin
          cnt_nxt = cnt_r;
        end else if (cnt_r == CONVERT_N_LAST) begin
          cnt_nxt = '0;
          if (!convert_n_low) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt = '0;
      end
    endcase
    // high at release also rises here
    if (cal_rise) begin
      state_nxt = ST_CAL;
      cnt_nxt = CAL_SYNC_CNT;
      set_done = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_WAKE;
      cnt_r <= '0;
      pol_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (convert_n_start) begin
        pol_r <= syn2_r[PIN_POL];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result buffer
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  logic has_data_r;
  logic load;

  assign load = fifo_out_valid && !has_data_r;

  acsc_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(push_now),
    .in_ready(fifo_in_ready),
    .in_data(code_word(sample_data, pol_r)),
    .out_valid(fifo_out_valid),
    .out_ready(!has_data_r),
    .out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serial transmitter
  acsc_tx_t tx_r;
  acsc_tx_t tx_nxt;
  logic [TX_CNT_W-1:0] tcnt_r;
  logic [TX_CNT_W-1:0] tcnt_nxt;
  logic [IDX_W-1:0] idx_r;
  logic [IDX_W-1:0] idx_nxt;
  logic sclk_r;
  logic sclk_nxt;
  logic tx_done;
  logic tx_go;
  logic ready_n_r;
  logic [WORD_W-1:0] word_r;
  logic [WORD_W-1:0] word_cur;

  assign tx_go = has_data_r && !ready_n_r && cs_low;
  assign word_cur = load ? fifo_out_data : word_r;

  always_comb begin
    tx_nxt = tx_r;
    tcnt_nxt = tcnt_r + 1'b1;
    idx_nxt = idx_r;
    sclk_nxt = 1'b0;
    tx_done = 1'b0;
    case (tx_r)
      TX_IDLE: begin
        tcnt_nxt = '0;
        idx_nxt = '0;
        if (tx_go) begin
          tx_nxt = master ? TX_LEAD : TX_SHIFT;
        end
      end
      TX_LEAD: begin
        if (tcnt_r == LEAD_LAST) begin
          tx_nxt = TX_SHIFT;
          sclk_nxt = 1'b1;
        end
      end
      TX_SHIFT: begin
        tcnt_nxt = '0;
        if (master) begin
          sclk_nxt = !sclk_r;
          if (sclk_r && idx_r == IDX_LAST) begin
            tx_nxt = TX_TAIL;
          end else if (sclk_r) begin
            idx_nxt = idx_r + 1'b1;
          end
        end else if (sclk_fall) begin
          if (idx_r == IDX_LAST) begin
            tx_nxt = TX_IDLE;
            tx_done = 1'b1;
          end else begin
            idx_nxt = idx_r + 1'b1;
          end
        end
      end
      TX_TAIL: begin
        if (tcnt_r == TAIL_LAST) begin
          tx_nxt = TX_IDLE;
          tx_done = 1'b1;
        end
      end
      default: begin
        tx_nxt = TX_IDLE;
      end
    endcase
    if (!cs_low) begin
      tx_nxt = TX_IDLE;
      idx_nxt = '0;
      sclk_nxt = 1'b0;
      tx_done = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_r <= TX_IDLE;
      tcnt_r <= '0;
      idx_r <= '0;
      sclk_r <= 1'b0;
    end else begin
      tx_r <= tx_nxt;
      tcnt_r <= tcnt_nxt;
      idx_r <= idx_nxt;
      sclk_r <= sclk_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ready and held word
  logic [1:0] lead_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_r <= '0;
      has_data_r <= 1'b0;
      lead_r <= '0;
      ready_n_r <= 1'b1;
    end else begin
      word_r <= word_cur;
      if (load) begin
        has_data_r <= 1'b1;
        lead_r <= MSB_LEAD_LD;
      end else if (lead_r != '0) begin
        lead_r <= lead_r - 1'b1;
      end
      if (tx_done) begin
        has_data_r <= 1'b0;
        ready_n_r <= 1'b1;
      end else if (lead_r == 2'h1 || (set_done && !has_data_r)) begin
        ready_n_r <= 1'b0;
      end else if (convert_n_start && !has_data_r) begin
        ready_n_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers
  logic serial_out_r;
  logic serial_out_oe_r;
  logic sclk_out_oe_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_r <= 1'b0;
      serial_out_oe_r <= 1'b0;
      sclk_out_oe_r <= 1'b0;
    end else begin
      serial_out_r <= pick_bit(word_cur, idx_nxt);
      serial_out_oe_r <= cs_low;
      sclk_out_oe_r <= cs_low && master;
    end
  end

  assign ready_n = ready_n_r;
  assign serial_out = serial_out_r;
  assign serial_out_oe = serial_out_oe_r;
  assign sclk_out = sclk_r;
  assign sclk_out_oe = sclk_out_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  localparam int A_CONVERT_N = CONVERT_N_MAX;
  localparam int A_LEAD = SCLK_LEAD_CNT + 1;
  localparam int A_TAIL = READY_TAIL;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  wake_ready_a: assert property ((state_r == ST_WAKE) && (cnt_r == wake_last) && !cal_rise
    |=> !ready_n_r && state_r == ST_IDLE) else $error("ready not low after wake-up");
  cal_ready_a: assert property ((state_r == ST_CAL) && (cnt_r == CAL_LAST) && !cal_rise && !has_data_r
    |=> !ready_n_r) else $error("ready not low after calibration");
  cal_entry_a: assert property (cal_rise |=> state_r == ST_CAL && cnt_r == CAL_SYNC_CNT)
    else $error("calibration not entered");
  convert_n_start_a: assert property (convert_n_start |=> state_r == ST_CONVERT_N && cnt_r == '0)
    else $error("conversion did not start");
  convert_n_time_a: assert property ($rose(state_r == ST_CONVERT_N) && !fifo_out_valid && !has_data_r
    |-> ##[1:A_CONVERT_N] (!ready_n_r || state_r == ST_CAL)) else $error("conversion too long");
  back2back_a: assert property ((state_r == ST_CONVERT_N) && (cnt_r == CONVERT_N_LAST) && convert_n_low && !cal_rise
    |=> state_r == ST_CONVERT_N && cnt_r == '0) else $error("continuous conversion broken");
  msb_lead_a: assert property ($fell(ready_n_r) && has_data_r
    |-> $past(has_data_r, MSB_LEAD) && serial_out_r == word_r[WORD_W-1]) else $error("msb not ahead of ready");
  hiz_cs_a: assert property (!cs_low |=> !serial_out_oe_r && !sclk_out_oe_r)
    else $error("pins driven with select high");
  sclk_half_a: assert property ((tx_r == TX_SHIFT) && master && cs_low && $past(tx_r == TX_SHIFT)
    |-> sclk_r != $past(sclk_r)) else $error("serial clock not half rate");
  first_sclk_a: assert property ($rose(tx_r == TX_LEAD) |-> ##[A_LEAD:A_LEAD] ($rose(sclk_r) || !cs_low))
    else $error("first serial clock late");
  ready_tail_a: assert property ((tx_r == TX_SHIFT) && master && sclk_r && (idx_r == IDX_LAST) && cs_low
    |-> ##[A_TAIL:A_TAIL] (ready_n_r || !cs_low)) else $error("ready tail wrong");
  slave_end_a: assert property ((tx_r == TX_SHIFT) && !master && sclk_fall && cs_low && (idx_r == IDX_LAST)
    |=> ready_n_r && !has_data_r) else $error("slave read did not end");

  cal_run_c: cover property ((state_r == ST_CAL) ##1 (state_r == ST_IDLE));
  cont_convert_n_c: cover property ((state_r == ST_CONVERT_N) && (cnt_r == CONVERT_N_LAST) ##1 (state_r == ST_CONVERT_N));
  master_read_c: cover property ((tx_r == TX_TAIL) && tx_done);
  slave_read_c: cover property ((tx_r == TX_SHIFT) && !master && tx_done);

endmodule

// [hw/acsc_fifo.sv]
/*
  result fifo of flip-flops, width and depth as parameters, valid and ready on both sides.
  assumes one clock and an asynchronous active low reset shared with the writer and reader.
*/
`timescale 1ns/10ps
module acsc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_size
    $error("fifo depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_ptr_r;
  logic [AW:0] rd_ptr_r;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;

  ////////////////////////////////////////////////////////////////////////////
  // status
  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_r[rd_ptr_r[AW-1:0]];
  assign do_wr = in_valid && !full;
  assign do_rd = out_ready && !empty;

  ////////////////////////////////////////////////////////////////////////////
  // pointers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  // storage
  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

endmodule

// [hw/acsc_pkg.sv]
/*
  constants, pin indices and state types of the converter sequence and serial read-out controller.
  assumes one 10 mhz system clock that stands in for the converter master clock, one cycle per master clock.
*/
// Contract
// - ready falls after wake-up: 1536 clocks, 1200 clocks with the internal oscillator
// - calibrate rise: ready falls 85218 clocks later
// - calibrate high at reset release also calibrates
// - conversion starts within two clocks of convert
// - start to ready falling within 84 clocks
// - convert held low: result every 80 clocks
// - ready tied to convert: period 82 clocks
// - ready falls when each conversion completes
// - role select picks clock master or slave
// - master mode: msb stable before ready falls
// - master: ready rises 8 clocks after last rise
// - master: first clock rise 8 after select
// - select high: data and clock high impedance
// - slave: ready rises after final host falling edge
package acsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and fifo depth
  localparam int WORD_W_DEF = 16;
  localparam int FIFO_DEPTH_DEF = 16;
  localparam int CNT_W = 17;
  localparam int TX_CNT_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // timing, master clock cycles unless named otherwise
  localparam int CLK_PERIOD_NS = 100;
  localparam int WAKE_EXT_MCLK = 1536;
  localparam int WAKE_INT_US = 120;
  localparam int WAKE_INT_CYC = (WAKE_INT_US * 1000) / CLK_PERIOD_NS;
  localparam int CAL_MCLK = 85218;
  localparam int SYNC_LAT = 2;
  localparam int CONVERT_N_START_MAX = 2;
  localparam int CONVERT_N_PERIOD = 80;
  localparam int CONVERT_N_TIE_PERIOD = 82;
  localparam int CONVERT_N_MAX = 84;
  localparam int CONVERT_N_PIPE = 4;
  localparam int CONVERT_N_TO_READY = CONVERT_N_TIE_PERIOD - SYNC_LAT - 1;
  localparam int PUSH_AT = CONVERT_N_TO_READY - CONVERT_N_PIPE;
  localparam int MSB_LEAD = 2;
  localparam int SCLK_LEAD = 8;
  localparam int READY_TAIL = 8;
  localparam int SCLK_LEAD_CNT = SCLK_LEAD - SYNC_LAT - 2;
  localparam int TAIL_CNT = READY_TAIL - 2;

  localparam logic [CNT_W-1:0] CONVERT_N_LAST = CNT_W'(CONVERT_N_PERIOD - 1);
  localparam logic [CNT_W-1:0] PUSH_CNT = CNT_W'(PUSH_AT);
  localparam logic [CNT_W-1:0] CAL_SYNC_CNT = CNT_W'(SYNC_LAT + 1);
  localparam logic [CNT_W-1:0] WAKE_EXT_LAST = CNT_W'(WAKE_EXT_MCLK - 1);
  localparam logic [CNT_W-1:0] WAKE_INT_LAST = CNT_W'(WAKE_INT_CYC - 1);
  localparam logic [TX_CNT_W-1:0] LEAD_LAST = TX_CNT_W'(SCLK_LEAD_CNT);
  localparam logic [TX_CNT_W-1:0] TAIL_LAST = TX_CNT_W'(TAIL_CNT);
  localparam logic [1:0] MSB_LEAD_LD = 2'(MSB_LEAD);

  ////////////////////////////////////////////////////////////////////////////
  // synchronised pin indices and their reset levels
  localparam int PIN_COUNT = 7;
  localparam int PIN_CAL = 0;
  localparam int PIN_CONVERT_N = 1;
  localparam int PIN_POL = 2;
  localparam int PIN_ROLE = 3;
  localparam int PIN_OSC = 4;
  localparam int PIN_CS = 5;
  localparam int PIN_SCLK = 6;
  localparam logic [PIN_COUNT-1:0] PIN_RST = 7'h22;

  ////////////////////////////////////////////////////////////////////////////
  // states
  typedef enum logic [1:0] {ST_WAKE, ST_CAL, ST_IDLE, ST_CONVERT_N} acsc_state_t;
  typedef enum logic [1:0] {TX_IDLE, TX_LEAD, TX_SHIFT, TX_TAIL} acsc_tx_t;

endpackage
